// file: verilog/uhm_pkg.sv
/*
 * uhm_pkg: constants for the host pin interface and modem logic of the serial controller.
 * assumes: one clock, synchronous reset, 3-bit register select, 8-bit data.
 */
package uhm_pkg;
    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int IER_W  = 4;

    // ----------------------------------------------------------------
    // register select codes
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_IER = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_FCR = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_MCR = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_MSR = 3'h6;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int MSR_DCTS = 0;
    localparam int MSR_DDSR = 1;
    localparam int MSR_TERI = 2;
    localparam int MSR_DDCD = 3;
    localparam int MSR_CTS  = 4;
    localparam int MSR_DSR  = 5;
    localparam int MSR_RI   = 6;
    localparam int MSR_DCD  = 7;
    localparam int MCR_DTR  = 0;
    localparam int MCR_RTS  = 1;
    localparam int FCR_FIFO = 0;
    localparam int FCR_DMA  = 3;
    localparam int IER_RXAV = 0;
    localparam int IER_THRE = 1;
    localparam int IER_RXER = 2;
    localparam int IER_MSTS = 3;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
    localparam logic [IER_W-1:0]  RST_IER  = 4'h0;
endpackage

// file: verilog/uhm_sync.sv
/*
 * uhm_sync: two flip-flop synchroniser for a vector of pin inputs.
 * assumes: every bit is a level from outside the mclk domain.
 */
`timescale 1ns/10ps
module uhm_sync #(
    parameter int              W       = 1,
    parameter logic [W-1:0]    RST_VAL = '0
) (
    // clock and reset
    input  wire logic          mclk,
    input  wire logic          srst,
    // levels
    input  wire logic [W-1:0]  din,
    output logic      [W-1:0]  dout
);
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } uhm_sync_t;

    uhm_sync_t st_r;
    uhm_sync_t st_nxt;

    always_comb begin
        st_nxt        = st_r;
        st_nxt.stage1 = din;
        st_nxt.stage2 = st_r.stage1;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            st_r <= '{stage1: RST_VAL, stage2: RST_VAL};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dout = st_r.stage2;
endmodule // uhm_sync

// file: verilog/uhm_pins.sv
/*
 * uhm_pins: host pin interface, modem status and control, interrupt line,
 * dma ready pins of the serial controller.
 * assumes: the uart core behind it does shifting, fifos and baud timing and
 * reports its fifo levels and interrupt sources on plain same-clock ports.
 */
// How it works
// - selected only when both high selects are high and low select low
// - rising address strobe latches register select and whether the three chip selects select the device
// - read strobe low while selected puts addressed register on output bus
// - write strobe low while selected stores input bus into addressed register
// - separate one-way 8-bit input and output data buses
// - status bit 4 shows clear-to-send, bit 0 its change since last read
// - status bit 7 shows carrier detect, bit 3 its change since last read
// - status bit 5 shows data-set-ready, bit 1 its change since last read
// - status bit 6 is the complement of the ring indicator input
// - status bit 2 set when ring input went low to high since last read
// - enabled modem interrupt fires on any cts, dcd or dsr change
// - terminal-ready pin low while its control bit is set
// - request-to-send pin low while control bit 1 is set
// - interrupt pin high while any enabled source is active
// - interrupt pin drops once its source is serviced or on reset
// - receiver runs from a separate 16x baud receive clock
// - serial output held at mark level during reset
// - select-indication output high while chip selects select the device
// - mode 0: transmit-ready low when tx empty, high after first character
// - mode 1: transmit-ready low when tx empty, high only when tx full
// - mode 0: receive-ready low while any character held, else high
// - mode 1: receive-ready low at trigger or timeout, high when emptied
`timescale 1ns/10ps
module uhm_pins
    import uhm_pkg::*;
(
    // clock and reset
    input  wire logic                        mclk,
    input  wire logic                        srst,
    // host parallel bus
    input  wire logic [uhm_pkg::ADDR_W-1:0]  address,
    input  wire logic                        adsN,
    input  wire logic                        selectHiA,
    input  wire logic                        selectHiB,
    input  wire logic                        selectLoN,
    input  wire logic                        readN,
    input  wire logic                        writeN,
    input  wire logic [uhm_pkg::DATA_W-1:0]  inData,
    output logic      [uhm_pkg::DATA_W-1:0]  outData,
    output logic                             csOut,
    output logic                             drvDisable,
    output logic                             intr,
    // modem lines
    input  wire logic                        ctsN,
    input  wire logic                        dsrN,
    input  wire logic                        dcdN,
    input  wire logic                        ringIndicatorN,
    output logic                             dtrN,
    output logic                             rtsN,
    // serial lines and receive clock
    input  wire logic                        sin,
    input  wire logic                        rclk,
    output logic                             sout,
    // dma ready pins
    output logic                             txRdyN,
    output logic                             rxRdyN,
    // uart core side
    input  wire logic [uhm_pkg::DATA_W-1:0]  coreRdData,
    input  wire logic                        coreTxSerial,
    input  wire logic                        coreTxEmpty,
    input  wire logic                        coreTxFull,
    input  wire logic                        coreRxEmpty,
    input  wire logic                        coreRxTrigger,
    input  wire logic                        coreRxTimeout,
    input  wire logic                        coreRxError,
    input  wire logic                        coreThrEmpty,
    output logic                             coreRd,
    output logic                             coreWr,
    output logic      [uhm_pkg::ADDR_W-1:0]  coreAddr,
    output logic      [uhm_pkg::DATA_W-1:0]  coreWrData,
    output logic                             coreRxSerial,
    output logic                             coreRxTick,
    output logic                             fifoEnable,
    output logic                             dmaModeSelect
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    localparam int SW = ADDR_W + DATA_W + 12;
    localparam logic [SW-1:0] SYNC_RST = {{ADDR_W{1'b0}}, {DATA_W{1'b0}},
                                          1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1,
                                          1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

    logic [SW-1:0]     pinRaw;
    logic [SW-1:0]     pinSync;
    logic [ADDR_W-1:0] addrS;
    logic [DATA_W-1:0] dataS;
    logic              adsS;
    logic              hiAS;
    logic              hiBS;
    logic              loNS;
    logic              rdNS;
    logic              wrNS;
    logic              ctsNS;
    logic              dsrNS;
    logic              dcdNS;
    logic              riNS;
    logic              sinS;
    logic              rclkS;

    assign pinRaw = {address, inData, adsN, selectHiA, selectHiB, selectLoN, readN,
                     writeN, ctsN, dsrN, dcdN, ringIndicatorN, sin, rclk};
    assign {addrS, dataS, adsS, hiAS, hiBS, loNS, rdNS, wrNS,
            ctsNS, dsrNS, dcdNS, riNS, sinS, rclkS} = pinSync;

    uhm_sync #(
        .W       (SW),
        .RST_VAL (SYNC_RST)
    ) u_sync (
        .mclk (mclk),
        .srst (srst),
        .din  (pinRaw),
        .dout (pinSync)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic isSelected(input logic hiA, input logic hiB,
                                        input logic loN);
        return hiA & hiB & ~loN;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic              adsPrev;
        logic              rdPrev;
        logic              wrPrev;
        logic              rclkPrev;
        logic [ADDR_W-1:0] addrLat;
        logic              selLat;
        logic [IER_W-1:0]  irq_enable_reg;
        logic [DATA_W-1:0] fcr;
        logic [DATA_W-1:0] mcr;
        logic [3:0]        msrDelta;
        logic              ctsPrev;
        logic              dsrPrev;
        logic              dcdPrev;
        logic              riPrev;
        logic [DATA_W-1:0] outData;
        logic              drvDisable;
        logic              csOut;
        logic              intr;
        logic              dtrN;
        logic              rtsN;
        logic              sout;
        logic              txRdyN;
        logic              rxRdyN;
        logic              coreRd;
        logic              coreWr;
        logic [ADDR_W-1:0] coreAddr;
        logic [DATA_W-1:0] coreWrData;
        logic              coreRxSerial;
        logic              coreRxTick;
    } uhm_state_t;

    uhm_state_t st_r;
    uhm_state_t st_nxt;

    logic [DATA_W-1:0] msrView;
    logic              rdFall;
    logic              wrFall;
    logic              mode1;
    logic              msIrq;

    always_comb begin
        msrView           = RST_BYTE;
        msrView[MSR_CTS]  = ~ctsNS;
        msrView[MSR_DSR]  = ~dsrNS;
        msrView[MSR_RI]   = ~riNS;
        msrView[MSR_DCD]  = ~dcdNS;
        msrView[3:0]      = st_r.msrDelta;
        rdFall = st_r.rdPrev & ~rdNS & st_r.selLat;
        wrFall = st_r.wrPrev & ~wrNS & st_r.selLat;
        mode1  = st_r.fcr[FCR_FIFO] & st_r.fcr[FCR_DMA];
        msIrq  = st_r.msrDelta[MSR_DCTS] | st_r.msrDelta[MSR_DDSR]
               | st_r.msrDelta[MSR_DDCD];

        st_nxt          = st_r;
        st_nxt.adsPrev  = adsS;
        st_nxt.rdPrev   = rdNS;
        st_nxt.wrPrev   = wrNS;
        st_nxt.rclkPrev = rclkS;
        st_nxt.ctsPrev  = ctsNS;
        st_nxt.dsrPrev  = dsrNS;
        st_nxt.dcdPrev  = dcdNS;
        st_nxt.riPrev   = riNS;

        // ----------------------------------------------------------------
        // address strobe latch
        // ----------------------------------------------------------------
        if (~st_r.adsPrev & adsS) begin
            st_nxt.addrLat = addrS;
            st_nxt.selLat  = isSelected(hiAS, hiBS, loNS);
        end
        st_nxt.csOut = isSelected(hiAS, hiBS, loNS);

        // ----------------------------------------------------------------
        // read path
        // ----------------------------------------------------------------
        st_nxt.coreRd = rdFall;
        if (~rdNS & st_r.selLat) begin
            st_nxt.drvDisable = 1'b0;
            case (st_r.addrLat)
                ADDR_IER: st_nxt.outData = {{(DATA_W-IER_W){1'b0}}, st_r.irq_enable_reg};
                ADDR_MCR: st_nxt.outData = st_r.mcr;
                ADDR_MSR: st_nxt.outData = msrView;
                default:  st_nxt.outData = coreRdData;
            endcase
        end else begin
            st_nxt.drvDisable = 1'b1;
            st_nxt.outData    = RST_BYTE;
        end

        // ----------------------------------------------------------------
        // write path
        // ----------------------------------------------------------------
        st_nxt.coreWr = wrFall;
        if (wrFall) begin
            st_nxt.coreAddr   = st_r.addrLat;
            st_nxt.coreWrData = dataS;
            case (st_r.addrLat)
                ADDR_IER: st_nxt.irq_enable_reg = dataS[IER_W-1:0];
                ADDR_FCR: st_nxt.fcr = dataS;
                ADDR_MCR: st_nxt.mcr = dataS;
                default:  st_nxt.irq_enable_reg = st_r.irq_enable_reg;
            endcase
        end

        // ----------------------------------------------------------------
        // modem status deltas: clear on read, a new change wins
        // ----------------------------------------------------------------
        if (rdFall && st_r.addrLat == ADDR_MSR) begin
            st_nxt.msrDelta = 4'h0;
        end
        if (st_r.ctsPrev != ctsNS) begin
            st_nxt.msrDelta[MSR_DCTS] = 1'b1;
        end
        if (st_r.dsrPrev != dsrNS) begin
            st_nxt.msrDelta[MSR_DDSR] = 1'b1;
        end
        if (st_r.dcdPrev != dcdNS) begin
            st_nxt.msrDelta[MSR_DDCD] = 1'b1;
        end
        if (~st_r.riPrev & riNS) begin
            st_nxt.msrDelta[MSR_TERI] = 1'b1;
        end

        // ----------------------------------------------------------------
        // modem control and serial pins
        // ----------------------------------------------------------------
        st_nxt.dtrN         = ~st_r.mcr[MCR_DTR];
        st_nxt.rtsN         = ~st_r.mcr[MCR_RTS];
        st_nxt.sout         = coreTxSerial;
        st_nxt.coreRxSerial = sinS;
        st_nxt.coreRxTick   = ~st_r.rclkPrev & rclkS;

        // ----------------------------------------------------------------
        // interrupt line
        // ----------------------------------------------------------------
        st_nxt.intr = (st_r.irq_enable_reg[IER_RXAV] & ~coreRxEmpty)
                    | (st_r.irq_enable_reg[IER_THRE] & coreThrEmpty)
                    | (st_r.irq_enable_reg[IER_RXER] & coreRxError)
                    | (st_r.irq_enable_reg[IER_MSTS] & msIrq);

        // ----------------------------------------------------------------
        // dma ready pins
        // ----------------------------------------------------------------
        if (!mode1) begin
            st_nxt.txRdyN = ~coreTxEmpty;
            st_nxt.rxRdyN = coreRxEmpty;
        end else begin
            if (coreTxEmpty) begin
                st_nxt.txRdyN = 1'b0;
            end else if (coreTxFull) begin
                st_nxt.txRdyN = 1'b1;
            end
            if (coreRxEmpty) begin
                st_nxt.rxRdyN = 1'b1;
            end else if (coreRxTrigger | coreRxTimeout) begin
                st_nxt.rxRdyN = 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            st_r            <= '0;
            st_r.adsPrev    <= 1'b1;
            st_r.rdPrev     <= 1'b1;
            st_r.wrPrev     <= 1'b1;
            st_r.ctsPrev    <= 1'b1;
            st_r.dsrPrev    <= 1'b1;
            st_r.dcdPrev    <= 1'b1;
            st_r.riPrev     <= 1'b1;
            st_r.irq_enable_reg        <= RST_IER;
            st_r.fcr        <= RST_BYTE;
            st_r.mcr        <= RST_BYTE;
            st_r.drvDisable <= 1'b1;
            st_r.dtrN       <= 1'b1;
            st_r.rtsN       <= 1'b1;
            st_r.sout       <= 1'b1;
            st_r.txRdyN     <= 1'b0;
            st_r.rxRdyN     <= 1'b1;
            st_r.coreRxSerial <= 1'b1;
            st_r.intr       <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign outData       = st_r.outData;
    assign csOut         = st_r.csOut;
    assign drvDisable    = st_r.drvDisable;
    assign intr          = st_r.intr;
    assign dtrN          = st_r.dtrN;
    assign rtsN          = st_r.rtsN;
    assign sout          = st_r.sout;
    assign txRdyN        = st_r.txRdyN;
    assign rxRdyN        = st_r.rxRdyN;
    assign coreRd        = st_r.coreRd;
    assign coreWr        = st_r.coreWr;
    assign coreAddr      = st_r.coreAddr;
    assign coreWrData    = st_r.coreWrData;
    assign coreRxSerial  = st_r.coreRxSerial;
    assign coreRxTick    = st_r.coreRxTick;
    assign fifoEnable    = st_r.fcr[FCR_FIFO];
    assign dmaModeSelect = st_r.fcr[FCR_DMA];
endmodule // uhm_pins

// file: bench/uhm_pins_properties.sv
/* uhm_pins_properties: timing relations on the pins of uhm_pins.
   assumes: bound into every uhm_pins, one mclk domain, sync reset. */
`timescale 1ns/10ps
module uhm_pins_properties
    import uhm_pkg::*;
(
    // clock and reset
    input wire logic                       mclk,
    input wire logic                       srst,
    // host pins
    input wire logic                       selectHiA,
    input wire logic                       selectHiB,
    input wire logic                       selectLoN,
    input wire logic                       readN,
    input wire logic                       writeN,
    input wire logic                       csOut,
    input wire logic                       drvDisable,
    input wire logic                       dtrN,
    input wire logic                       rtsN,
    input wire logic                       txRdyN,
    input wire logic                       rxRdyN,
    // core side
    input wire logic                       coreTxEmpty,
    input wire logic                       coreTxFull,
    input wire logic                       coreRxEmpty,
    input wire logic                       coreRxTrigger,
    input wire logic                       coreRxTimeout,
    input wire logic                       coreRd,
    input wire logic                       coreWr,
    input wire logic [uhm_pkg::ADDR_W-1:0] coreAddr,
    input wire logic [uhm_pkg::DATA_W-1:0] coreWrData,
    input wire logic                       fifoEnable,
    input wire logic                       dmaModeSelect
);
    logic [2:0] sinceRst_r;
    logic       settled, liveSel, mode1;
    assign settled = sinceRst_r == 3'h7;
    assign liveSel = selectHiA & selectHiB & ~selectLoN;
    assign mode1   = fifoEnable & dmaModeSelect;
    always_ff @(posedge mclk) begin
        if (srst) begin
            sinceRst_r <= 3'h0;
        end else if (!settled) begin
            sinceRst_r <= sinceRst_r + 3'h1;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    a_dtr_write: assert property (
        coreWr && coreAddr == ADDR_MCR |=> dtrN == !coreWrData[MCR_DTR])
        else $error("dtrN not set by control write");
    a_rts_write: assert property (
        coreWr && coreAddr == ADDR_MCR |=> rtsN == !coreWrData[MCR_RTS])
        else $error("rtsN not set by control write");
    a_cs_live: assert property (
        settled && $past(liveSel, 3) == $past(liveSel, 4) |-> csOut == $past(liveSel, 3))
        else $error("csOut does not follow selects");
    a_rd_strobe: assert property (
        coreRd |-> !$past(readN, 2) ##1 !coreRd)
        else $error("read pulse without strobe");
    a_wr_strobe: assert property (
        coreWr |-> !$past(writeN, 2) ##1 !coreWr)
        else $error("write pulse without strobe");
    a_drv_idle: assert property (
        readN [*6] |-> drvDisable)
        else $error("driver enabled without read");
    a_tx_mode0: assert property (
        settled && !mode1 && !$past(mode1) |-> txRdyN == !$past(coreTxEmpty))
        else $error("txRdyN wrong in mode 0");
    a_rx_mode0: assert property (
        settled && !mode1 && !$past(mode1) |-> rxRdyN == $past(coreRxEmpty))
        else $error("rxRdyN wrong in mode 0");
    a_tx_full: assert property (
        settled && mode1 && $past(mode1) && $past(coreTxFull) |-> txRdyN)
        else $error("txRdyN low with full fifo");
    a_rx_trig: assert property (
        settled && mode1 && $past(mode1)
        && $past(!coreRxEmpty && (coreRxTrigger || coreRxTimeout)) |-> !rxRdyN)
        else $error("rxRdyN high at trigger");
endmodule // uhm_pins_properties

bind uhm_pins uhm_pins_properties props_u (.*);

// file: bench/uhm_host_model.sv
/* uhm_host_model: host processor on the parallel pin bus.
   assumes: strobes outlast the sync path. */
`timescale 1ns/10ps
module uhm_host_model
    import uhm_pkg::*;
(
    // clock
    input wire logic                       mclk,
    // bus pins
    input wire logic [uhm_pkg::DATA_W-1:0] outData,
    output logic     [uhm_pkg::ADDR_W-1:0] address,
    output logic                           adsN,
    output logic     [2:0]                 sel,
    output logic                           readN,
    output logic                           writeN,
    output logic     [uhm_pkg::DATA_W-1:0] inData
);
    initial {address, adsN, sel, readN, writeN, inData} = {3'h0, 1'b1, 3'b001, 2'b11, 8'h00};
    task automatic hold(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // sel is hiA, hiB, loN; rising strobe latches them
    task automatic latch(input logic [2:0] a, input logic [2:0] s);
        address = a;
        sel = s;
        adsN = 1'b0;
        hold(4);
        adsN = 1'b1;
        hold(4);
    endtask
    // data held through the strobe, scrambled after
    task automatic wr(input logic [7:0] d);
        inData = d;
        writeN = 1'b0;
        hold(6);
        writeN = 1'b1;
        inData = ~d;
        hold(4);
    endtask
    // data taken while strobe still low
    task automatic rd(output logic [7:0] d);
        readN = 1'b0;
        hold(3);
        d = outData;
        hold(3);
        readN = 1'b1;
        hold(5);
    endtask
endmodule // uhm_host_model

// file: bench/uart_host_modem_dma_pins_tb.sv
/* uart_host_modem_dma_pins_tb: scenarios for uhm_pins.
   assumes: host model drives the bus, bench drives modem and core pins. */
`timescale 1ns/10ps
module uart_host_modem_dma_pins_tb;
    import uhm_pkg::*;
    logic mclk = 1'b0, srst = 1'b1, rclk = 1'b0, txSer = 1'b0, sin = 1'b1;
    logic [3:0] mdmN = 4'hF;
    logic txEmpty = 1'b1, txFull = 1'b0, rxEmpty = 1'b1, rxTrig = 1'b0;
    logic rxTmo = 1'b0, rxErr = 1'b0, thrEmpty = 1'b0;
    logic [7:0] v;
    wire [2:0] addr, sel;
    wire [7:0] inData, outData;
    wire adsN, readN, writeN, csOut, intr, dtrN, rtsN, sout, txRdyN, rxRdyN;
    wire drvDis, rxSer, fifoEn, dmaSel;
    int nMismatch = 0, checks = 0, cyc = 0;
    always #4 mclk = ~mclk;
    always #36 rclk = ~rclk;
    uhm_host_model host_u (.mclk(mclk), .outData(outData), .address(addr), .adsN(adsN),
        .sel(sel), .readN(readN), .writeN(writeN), .inData(inData));
    uhm_pins dut_u (.mclk(mclk), .srst(srst), .address(addr), .adsN(adsN),
        .selectHiA(sel[2]), .selectHiB(sel[1]), .selectLoN(sel[0]), .readN(readN),
        .writeN(writeN), .inData(inData), .outData(outData), .csOut(csOut),
        .drvDisable(drvDis), .intr(intr), .ctsN(mdmN[0]), .dsrN(mdmN[1]), .dcdN(mdmN[2]),
        .ringIndicatorN(mdmN[3]), .dtrN(dtrN), .rtsN(rtsN), .sin(sin), .rclk(rclk),
        .sout(sout), .txRdyN(txRdyN), .rxRdyN(rxRdyN), .coreRdData(8'hA5),
        .coreTxSerial(txSer), .coreTxEmpty(txEmpty), .coreTxFull(txFull),
        .coreRxEmpty(rxEmpty), .coreRxTrigger(rxTrig), .coreRxTimeout(rxTmo),
        .coreRxError(rxErr), .coreThrEmpty(thrEmpty), .coreRd(), .coreWr(),
        .coreAddr(), .coreWrData(), .coreRxSerial(rxSer), .coreRxTick(), .fifoEnable(fifoEn),
        .dmaModeSelect(dmaSel));
    task automatic w(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            nMismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, nMismatch);
        if (nMismatch == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            nMismatch++;
            conclude();
        end
    end
    task automatic tMcr();
        sin = 1'b0;
        host_u.latch(ADDR_MCR, 3'b110);
        chk("csOut on", {7'h0, csOut}, 8'h01);
        chk("serial", {6'h0, sout, rxSer}, 8'h00);
        host_u.wr(8'h01);
        chk("dtr set", {6'h0, rtsN, dtrN}, 8'h02);
        host_u.wr(8'h02);
        chk("rts set", {6'h0, rtsN, dtrN}, 8'h01);
        host_u.rd(v);
        chk("mcr read", v, 8'h02);
        $display("test mcr done");
    endtask
    task automatic tRefuse();
        logic [2:0] bad [3] = '{3'b010, 3'b100, 3'b111};
        foreach (bad[i]) begin
            host_u.latch(ADDR_MCR, bad[i]);
            chk("csOut off", {7'h0, csOut}, 8'h00);
        end
        host_u.wr(8'h01);
        chk("refused wr", {6'h0, rtsN, dtrN}, 8'h01);
        host_u.rd(v);
        chk("refused rd", v, 8'h00);
        $display("test refuse done");
    endtask
    task automatic tModem();
        int lvl [3] = '{4, 5, 7};
        int dlt [3] = '{0, 1, 3};
        host_u.latch(ADDR_MSR, 3'b110);
        host_u.rd(v);
        host_u.rd(v);
        chk("msr idle", v, 8'h00);
        for (int i = 0; i < 3; i++) begin
            mdmN[i] = 1'b0;
            w(6);
            host_u.rd(v);
            chk("msr delta", v, 8'((1 << lvl[i]) | (1 << dlt[i])));
            host_u.rd(v);
            chk("msr level", v, 8'(1 << lvl[i]));
            mdmN[i] = 1'b1;
            w(6);
            host_u.rd(v);
            chk("msr back", v, 8'(1 << dlt[i]));
        end
        mdmN[3] = 1'b0;
        w(6);
        host_u.rd(v);
        chk("ring on", v, 8'h40);
        mdmN[3] = 1'b1;
        w(6);
        host_u.rd(v);
        chk("ring off", v, 8'h04);
        host_u.rd(v);
        chk("ring clear", v, 8'h00);
        $display("test modem done");
    endtask
    task automatic tIntr();
        host_u.latch(ADDR_IER, 3'b110);
        for (int i = 0; i < 3; i++) begin
            host_u.wr(8'(1 << i));
            chk("intr idle", {7'h0, intr}, 8'h00);
            {rxErr, thrEmpty, rxEmpty} = 3'b001 ^ 3'(1 << i);
            w(3);
            chk("intr source", {7'h0, intr}, 8'h01);
            {rxErr, thrEmpty, rxEmpty} = 3'b001;
            w(3);
            chk("intr serviced", {7'h0, intr}, 8'h00);
        end
        {rxErr, thrEmpty, rxEmpty} = 3'b110;
        host_u.wr(8'h08);
        chk("intr masked", {7'h0, intr}, 8'h00);
        {rxErr, thrEmpty, rxEmpty} = 3'b001;
        mdmN[2] = 1'b0;
        w(6);
        chk("intr modem", {7'h0, intr}, 8'h01);
        host_u.latch(ADDR_MSR, 3'b110);
        host_u.rd(v);
        chk("intr msr read", {7'h0, intr}, 8'h00);
        mdmN[2] = 1'b1;
        w(6);
        host_u.rd(v);
        $display("test intr done");
    endtask
    // s: txEmpty txFull rxEmpty rxTrig rxTmo; e: txRdyN rxRdyN
    task automatic dmaStep(input logic [4:0] s, input logic [1:0] e);
        {txEmpty, txFull, rxEmpty, rxTrig, rxTmo} = s;
        w(3);
        chk("dma pins", {6'h0, txRdyN, rxRdyN}, {6'h0, e});
    endtask
    task automatic tDma();
        dmaStep(5'b10100, 2'b01);
        dmaStep(5'b00000, 2'b10);
        dmaStep(5'b01110, 2'b11);
        host_u.latch(ADDR_FCR, 3'b110);
        host_u.wr(8'h09);
        host_u.rd(v);
        chk("fcr read", v, 8'hA5);
        chk("fcr bits", {6'h0, fifoEn, dmaSel}, 8'h03);
        dmaStep(5'b10100, 2'b01);
        dmaStep(5'b00000, 2'b01);
        dmaStep(5'b01010, 2'b10);
        dmaStep(5'b00000, 2'b10);
        dmaStep(5'b10100, 2'b01);
        dmaStep(5'b00001, 2'b00);
        $display("test dma done");
    endtask
    initial begin
        w(6);
        chk("reset pins", {drvDis, sout, dtrN, rtsN, intr, txRdyN, rxRdyN, csOut}, 8'hF2);
        srst = 1'b0;
        w(2);
        tMcr();
        tRefuse();
        tModem();
        tIntr();
        tDma();
        conclude();
    end
endmodule // uart_host_modem_dma_pins_tb
